// [hw/cmp_div_branch_pkg.sv]
package cmp_div_branch_pkg;
	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [4:0] OP_EXTEND          = 5'h1E;
	localparam logic [4:0] OP_IMM8_GROUP      = 5'h0C;
	localparam logic [4:0] OP_REG_REG_GROUP   = 5'h1D;
	localparam logic [4:0] OP_XOR_COMPARE_IMM = 5'h0E;
	localparam logic [4:0] OP_REGION_CALL     = 5'h03;
	localparam logic [2:0] SUB_BRANCH_NONZERO = 3'h1;
	localparam logic [4:0] FN_XOR_COMPARE     = 5'h0A;
	localparam logic [4:0] FN_SIGNED_DIV      = 5'h1A;
	localparam logic [4:0] FN_UNSIGNED_DIV    = 5'h1B;
	// ----------------------------------------------------------------
	// Registers and counts
	// ----------------------------------------------------------------
	localparam logic [4:0] FLAG_REG_INDEX     = 5'h18;
	localparam logic [4:0] LINK_REG_INDEX     = 5'h1F;
	localparam logic [31:0] STEP_COMPACT      = 32'h0000_0002;
	localparam logic [31:0] STEP_EXTENDED     = 32'h0000_0004;
	localparam logic [31:0] LINK_OFFSET       = 32'h0000_0006;
	localparam int          DIV_STEPS         = 32;
	localparam logic [5:0]  DIV_COUNT_LAST    = 6'h20;

	// Instruction in, with address and core mode bit
	typedef struct packed {
		logic        valid;
		logic [31:0] word;
		logic        extended;
		logic [31:0] pc;
		logic        compact_code_state;
	} instr_in_t;

	// Register file write
	typedef struct packed {
		logic        en;
		logic [4:0]  index;
		logic [31:0] data;
	} reg_write_t;
endpackage

// [hw/cmp_div_branch.sv]
`timescale 1ns/1ns
module cmp_div_branch (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	// Instruction stream
	input  wire cmp_div_branch_pkg::instr_in_t   instr,
	input  wire logic                            read_quot_rem,
	output logic                                 stall,
	// Register file read ports
	output logic [4:0]                           rd_index_a,
	output logic [4:0]                           rd_index_b,
	input  wire logic [31:0]                     rd_data_a,
	input  wire logic [31:0]                     rd_data_b,
	input  wire logic [31:0]                     flag_value,
	// Results
	output cmp_div_branch_pkg::reg_write_t       reg_write,
	output logic [31:0]                          next_pc,
	output logic                                 redirect,
	output logic [31:0]                          quotient_reg,
	output logic [31:0]                          remainder_reg,
	output logic                                 div_busy
);
	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	logic [15:0] lo_half;
	logic [15:0] hi_half;
	logic [4:0]  major;
	logic [15:0] ext_imm;
	logic        is_branch_nz;
	logic        is_cmp;
	logic        is_xor_compare_imm;
	logic        is_div;
	logic        is_unsigned_quotient_op;
	logic        is_call;
	logic        ext_ok;
	logic [2:0]  first_source_field;
	logic [2:0]  second_source_field;

	assign lo_half = instr.word[15:0];
	assign hi_half = instr.word[31:16];
	assign major   = lo_half[15:11];
	assign first_source_field  = lo_half[10:8];
	assign second_source_field = lo_half[7:5];
	assign ext_ok  = instr.extended && hi_half[15:11] == cmp_div_branch_pkg::OP_EXTEND
		&& lo_half[7:5] == 3'h0;
	assign ext_imm = {instr.word[20:16], instr.word[26:21], lo_half[4:0]};
	assign is_branch_nz = instr.valid && ext_ok
		&& major == cmp_div_branch_pkg::OP_IMM8_GROUP
		&& lo_half[10:8] == cmp_div_branch_pkg::SUB_BRANCH_NONZERO;
	assign is_cmp  = instr.valid && !instr.extended
		&& major == cmp_div_branch_pkg::OP_REG_REG_GROUP
		&& lo_half[4:0] == cmp_div_branch_pkg::FN_XOR_COMPARE;
	assign is_xor_compare_imm = instr.valid
		&& major == cmp_div_branch_pkg::OP_XOR_COMPARE_IMM
		&& (!instr.extended || ext_ok);
	assign is_div  = instr.valid && !instr.extended
		&& major == cmp_div_branch_pkg::OP_REG_REG_GROUP
		&& lo_half[4:0] == cmp_div_branch_pkg::FN_SIGNED_DIV;
	assign is_unsigned_quotient_op = instr.valid && !instr.extended
		&& major == cmp_div_branch_pkg::OP_REG_REG_GROUP
		&& lo_half[4:0] == cmp_div_branch_pkg::FN_UNSIGNED_DIV;
	assign is_call = instr.valid && instr.extended
		&& instr.word[31:27] == cmp_div_branch_pkg::OP_REGION_CALL
		&& !instr.word[26];

	// Fixed 3-bit to 5-bit map: codes 0,1 go to 16,17, others to 2..7
	function automatic logic [4:0] xlat(input logic [2:0] f);
		xlat = (f < 3'h2) ? {2'h2, f} : {2'h0, f};
	endfunction

	assign rd_index_a = xlat(first_source_field);
	assign rd_index_b = xlat(second_source_field);

	// ----------------------------------------------------------------
	// Compare and branch
	// ----------------------------------------------------------------
	logic [31:0] cmp_result;
	logic [31:0] xor_compare_imm_operand;
	logic [31:0] seq_pc;
	logic [31:0] branch_target;
	logic [31:0] call_target;
	logic [31:0] link_value;
	logic [31:0] link_sum;
	logic        take_branch;

	assign xor_compare_imm_operand = instr.extended ? {16'h0000, ext_imm}
		: {24'h000000, lo_half[7:0]};
	assign cmp_result = is_cmp ? (rd_data_a ^ rd_data_b)
		: (rd_data_a ^ xor_compare_imm_operand);
	assign seq_pc = instr.pc + (instr.extended ? cmp_div_branch_pkg::STEP_EXTENDED
		: cmp_div_branch_pkg::STEP_COMPACT);
	assign branch_target = instr.pc + cmp_div_branch_pkg::STEP_EXTENDED
		+ {{15{ext_imm[15]}}, ext_imm, 1'b0};
	assign take_branch = is_branch_nz && flag_value != 32'h0000_0000;
	// Upper bits from the delay-slot address, i.e. PC+4
	assign call_target = {seq_pc[31:28], instr.word[20:16], instr.word[25:21],
		instr.word[15:0], 2'h0};
	// Bit 0 of the sum is dropped on purpose: it carries the mode bit
	assign link_sum   = instr.pc + cmp_div_branch_pkg::LINK_OFFSET;
	assign link_value = {link_sum[31:1], instr.compact_code_state};

	// ----------------------------------------------------------------
	// Divider: restoring, one bit per cycle, no exception path
	// ----------------------------------------------------------------
	logic [31:0] quot_reg;
	logic [31:0] quot_next;
	logic [32:0] rem_reg;
	logic [32:0] rem_next;
	logic [31:0] dvsr_reg;
	logic [5:0]  cnt_reg;
	logic        neg_q_reg;
	logic        neg_r_reg;
	logic        busy_reg;
	logic        start;
	logic        sgn;
	logic [31:0] abs_a;
	logic [31:0] abs_b;
	logic [32:0] trial;
	logic        stall_now;

	assign start = (is_div || is_unsigned_quotient_op) && !stall_now;
	assign sgn   = is_div;
	assign abs_a = (sgn && rd_data_a[31]) ? -rd_data_a : rd_data_a;
	assign abs_b = (sgn && rd_data_b[31]) ? -rd_data_b : rd_data_b;
	assign trial = {rem_reg[31:0], quot_reg[31]} - {1'b0, dvsr_reg};
	assign rem_next  = trial[32] ? {rem_reg[31:0], quot_reg[31]} : trial;
	assign quot_next = {quot_reg[30:0], ~trial[32]};
	// Read waits for a running divide; a new divide waits too
	assign stall_now = busy_reg && (read_quot_rem || is_div || is_unsigned_quotient_op);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg  <= 1'b0;
			cnt_reg   <= 6'h00;
			quot_reg  <= 32'h0000_0000;
			rem_reg   <= 33'h0_0000_0000;
			dvsr_reg  <= 32'h0000_0000;
			neg_q_reg <= 1'b0;
			neg_r_reg <= 1'b0;
		end else if (start) begin
			busy_reg  <= 1'b1;
			cnt_reg   <= 6'h00;
			quot_reg  <= abs_a;
			rem_reg   <= 33'h0_0000_0000;
			dvsr_reg  <= abs_b;
			neg_q_reg <= sgn && (rd_data_a[31] ^ rd_data_b[31]);
			neg_r_reg <= sgn && rd_data_a[31];
		end else if (busy_reg) begin
			quot_reg <= quot_next;
			rem_reg  <= rem_next;
			cnt_reg  <= cnt_reg + 6'h01;
			if (cnt_reg == cmp_div_branch_pkg::DIV_COUNT_LAST - 6'h01)
				busy_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	logic div_done;
	assign div_done = busy_reg
		&& cnt_reg == cmp_div_branch_pkg::DIV_COUNT_LAST - 6'h01;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quotient_reg  <= 32'h0000_0000;
			remainder_reg <= 32'h0000_0000;
		end else if (div_done) begin
			// Zero divisor: all-ones quotient (1 for a signed divide of a negative dividend), dividend remainder; undefined
			quotient_reg  <= neg_q_reg ? -quot_next : quot_next;
			remainder_reg <= neg_r_reg ? -rem_next[31:0]
				: rem_next[31:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_write <= '0;
			next_pc   <= 32'h0000_0000;
			redirect  <= 1'b0;
			stall     <= 1'b0;
			div_busy  <= 1'b0;
		end else begin
			stall     <= stall_now;
			div_busy  <= busy_reg || start;
			reg_write.en    <= is_cmp || is_xor_compare_imm || is_call;
			reg_write.index <= is_call ? cmp_div_branch_pkg::LINK_REG_INDEX
				: cmp_div_branch_pkg::FLAG_REG_INDEX;
			reg_write.data  <= is_call ? link_value : cmp_result;
			redirect  <= take_branch || is_call;
			next_pc   <= take_branch ? branch_target
				: (is_call ? call_target : seq_pc);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_branch_taken;
		@(posedge clk) disable iff (!rst_n)
		take_branch |=> redirect && next_pc == $past(branch_target);
	endproperty
	a_branch_taken: assert property (p_branch_taken) else $error("branch lost");

	property p_branch_zero;
		@(posedge clk) disable iff (!rst_n)
		is_branch_nz && flag_value == 32'h0 |=> !redirect;
	endproperty
	a_branch_zero: assert property (p_branch_zero) else $error("bad branch");

	property p_cmp_write;
		@(posedge clk) disable iff (!rst_n)
		is_cmp |=> reg_write.en && reg_write.index == 5'h18
			&& reg_write.data == ($past(rd_data_a) ^ $past(rd_data_b));
	endproperty
	a_cmp_write: assert property (p_cmp_write) else $error("cmp wrong");

	property p_xor_compare_imm_short;
		@(posedge clk) disable iff (!rst_n)
		is_xor_compare_imm && !instr.extended |=> reg_write.data[31:8]
			== $past(rd_data_a[31:8]);
	endproperty
	a_xor_compare_imm_short: assert property (p_xor_compare_imm_short) else $error("xor_compare_imm ext");

	property p_call_link;
		@(posedge clk) disable iff (!rst_n)
		is_call |=> reg_write.index == 5'h1F && redirect
			&& next_pc[1:0] == 2'h0;
	endproperty
	a_call_link: assert property (p_call_link) else $error("call wrong");

	property p_pc_step;
		@(posedge clk) disable iff (!rst_n)
		instr.valid && !take_branch && !is_call && !instr.extended
			|=> next_pc == $past(instr.pc) + 32'h2;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc step");

	property p_div_len;
		@(posedge clk) disable iff (!rst_n)
		start |=> busy_reg [*8] ##24 busy_reg ##1 !busy_reg;
	endproperty
	a_div_len: assert property (p_div_len) else $error("div length");

	property p_read_stall;
		@(posedge clk) disable iff (!rst_n)
		busy_reg && read_quot_rem |=> stall;
	endproperty
	a_read_stall: assert property (p_read_stall) else $error("no stall");

	property p_unsigned_div;
		@(posedge clk) disable iff (!rst_n)
		start && is_unsigned_quotient_op && rd_data_b == 32'h1 |=> ##32
			quotient_reg == $past(rd_data_a, 33);
	endproperty
	a_unsigned_div: assert property (p_unsigned_div) else $error("unsigned_quotient_op");

	c_branch: cover property (@(posedge clk) disable iff (!rst_n) take_branch);
	c_div:    cover property (@(posedge clk) disable iff (!rst_n) div_done);
	c_call:   cover property (@(posedge clk) disable iff (!rst_n) is_call);
	c_stall:  cover property (@(posedge clk) disable iff (!rst_n) stall_now);
endmodule // cmp_div_branch

// [tb/compact_isa_cmp_div_branch_bench.sv]
`timescale 1ns/1ns
module compact_isa_cmp_div_branch_bench;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic                              clk = 1'b0;
	logic                              rst_n = 1'b0;
	cmp_div_branch_pkg::instr_in_t     instr = '0;
	logic                              read_quot_rem = 1'b0;
	logic [31:0]                       flag_value = 32'h0;
	logic [31:0]                       regs [32];
	logic [4:0]                        rd_index_a;
	logic [4:0]                        rd_index_b;
	logic [31:0]                       rd_data_a;
	logic [31:0]                       rd_data_b;
	logic                              stall;
	cmp_div_branch_pkg::reg_write_t    reg_write;
	logic [31:0]                       next_pc;
	logic                              redirect;
	logic [31:0]                       quotient_reg;
	logic [31:0]                       remainder_reg;
	logic                              div_busy;
	logic [4:0]                        idx_a;
	int                                err_count = 0;
	int                                num_checks = 0;
	int                                cyc = 0;

	always #5 clk = ~clk;
	// Register file answers in the same cycle as the index
	assign rd_data_a = regs[rd_index_a];
	assign rd_data_b = regs[rd_index_b];

	cmp_div_branch cmp_div_branch_i (
		.clk           (clk),
		.rst_n         (rst_n),
		.instr         (instr),
		.read_quot_rem (read_quot_rem),
		.stall         (stall),
		.rd_index_a    (rd_index_a),
		.rd_index_b    (rd_index_b),
		.rd_data_a     (rd_data_a),
		.rd_data_b     (rd_data_b),
		.flag_value    (flag_value),
		.reg_write     (reg_write),
		.next_pc       (next_pc),
		.redirect      (redirect),
		.quotient_reg  (quotient_reg),
		.remainder_reg (remainder_reg),
		.div_busy      (div_busy)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [31:0] ext(input logic [4:0] major,
		input logic [2:0] mid, input logic [15:0] imm);
		return {5'h1E, imm[10:5], imm[15:11], major, mid, 3'h0, imm[4:0]};
	endfunction

	// One instruction: present, let it be taken, sample the answer
	task automatic issue(input logic [31:0] w, input logic x,
		input logic [31:0] pc, input logic mode);
		@(posedge clk);
		instr <= '{valid: 1'b1, word: w, extended: x, pc: pc,
			compact_code_state: mode};
		#1 idx_a = rd_index_a;
		@(posedge clk);
		instr <= '0;
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_compare;
		regs[16] = 32'h1234_5678;
		regs[3] = 32'h0F0F_00FF;
		issue({16'h0000, 5'h1D, 3'h0, 3'h3, 5'h0A}, 1'b0, 32'h100, 1'b0);
		check("rd_index_a", 32'h10, idx_a);
		check("cmp en", 32'h1, reg_write.en);
		check("cmp index", 32'h18, reg_write.index);
		check("cmp data", regs[16] ^ regs[3], reg_write.data);
		check("cmp next_pc", 32'h102, next_pc);
	endtask

	task automatic t_cmp_imm;
		regs[2] = 32'hFFFF_0F0F;
		issue({16'h0000, 5'h0E, 3'h2, 8'hF0}, 1'b0, 32'h200, 1'b0);
		check("imm8 data", regs[2] ^ 32'h0000_00F0, reg_write.data);
		issue(ext(5'h0E, 3'h2, 16'h8001), 1'b1, 32'h300, 1'b0);
		check("imm16 data", regs[2] ^ 32'h0000_8001, reg_write.data);
		check("imm16 index", 32'h18, reg_write.index);
		check("imm16 next_pc", 32'h304, next_pc);
	endtask

	// Negative offset shows both the sign extension and the halfword scale
	task automatic t_branch;
		logic [15:0] off;
		logic [31:0] pc;
		off = 16'hFFF0;
		pc = 32'h0000_1000;
		for (int i = 0; i < 2; i++) begin
			flag_value <= (i == 0) ? 32'h0000_0100 : 32'h0;
			issue(ext(5'h0C, 3'h1, off), 1'b1, pc, 1'b0);
			check("br redirect", (i == 0), redirect);
			check("br next_pc", (i == 0) ?
				pc + 32'h4 + {{15{off[15]}}, off, 1'b0} : pc + 32'h4, next_pc);
		end
	endtask

	// Call at the last word of a region: upper bits follow the delay slot
	task automatic t_call;
		logic [25:0] t;
		logic [31:0] pc;
		logic [31:0] ret;
		logic [31:0] slot;
		t = 26'h2AB_CDEF;
		pc = 32'h1FFF_FFFC;
		ret = pc + 32'h6;
		slot = pc + 32'h4;
		// Slot after the call left free of jumps and extended forms
		issue({5'h03, 1'b0, t[20:16], t[25:21], t[15:0]}, 1'b1, pc, 1'b1);
		check("call redirect", 32'h1, redirect);
		check("call target", {slot[31:28], t, 2'h0}, next_pc);
		check("link en", 32'h1, reg_write.en);
		check("link index", 32'h1F, reg_write.index);
		check("link data", {ret[31:1], 1'b1}, reg_write.data);
	endtask

	// A read right before the divide must not hold it off
	task automatic t_divide(input logic [4:0] fn, input logic [2:0] ry,
		input logic [31:0] q, input logic [31:0] r, input logic vals);
		int n;
		@(posedge clk);
		read_quot_rem <= 1'b1;
		@(posedge clk);
		read_quot_rem <= 1'b0;
		instr <= '{valid: 1'b1, word: {16'h0000, 5'h1D, 3'h4, ry, fn},
			extended: 1'b0, pc: 32'h400, compact_code_state: 1'b0};
		@(posedge clk);
		instr <= '0;
		#1;
		check("div started", 32'h1, div_busy);
		check("no stall", 32'h0, stall);
		@(posedge clk);
		read_quot_rem <= 1'b1;
		@(posedge clk);
		read_quot_rem <= 1'b0;
		#1;
		check("read stalls", 32'h1, stall);
		n = 2;
		while (div_busy === 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
			#1;
		end
		check("div cycles", 32'd33, n);
		if (vals) begin
			check("quotient", q, quotient_reg);
			check("remainder", r, remainder_reg);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			err_count++;
			tally_and_finish();
		end
	end

	initial begin
		foreach (regs[i]) regs[i] = 32'h0;
		regs[4] = 32'hFFFF_FFF9;
		regs[5] = 32'h0000_0002;
		regs[7] = 32'h0000_0001;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check("reset en", 32'h0, reg_write.en);
		check("reset busy", 32'h0, div_busy);
		t_compare();
		t_cmp_imm();
		t_branch();
		t_call();
		t_divide(5'h1A, 3'h5, 32'hFFFF_FFFD, 32'hFFFF_FFFF, 1'b1);
		t_divide(5'h1B, 3'h5, 32'h7FFF_FFFC, 32'h0000_0001, 1'b1);
		// Unit divisor keeps the top bit of an unsigned dividend
		t_divide(5'h1B, 3'h7, 32'hFFFF_FFF9, 32'h0000_0000, 1'b1);
		// Zero divisor: only completion is defined
		t_divide(5'h1A, 3'h6, 32'h0, 32'h0, 1'b0);
		tally_and_finish();
	end
endmodule // compact_isa_cmp_div_branch_bench
